// [core/pps_params.svh]
// Offsets, field positions and reset values for the peripheral input pin select block.
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH
`define PPS_SEL_W 6
`define PPS_PIN_LSB 0
`define PPS_PIN_W 3
`define PPS_PORT_LSB 3
`define PPS_PORT_W 3
`define PPS_PINS_PER_PORT 8
`define PPS_NUM_PORTS 6
`define PPS_PORT_PRESENT_ALL 6'h3f
`define PPS_SEL_BASE 8'h00
`define PPS_SEL_STRIDE 8'h04
`define PPS_LEVEL_OFS 8'h40
`define PPS_RSVD_OFS 8'h44
`define PPS_ADR_W 8
`define PPS_SEL_RST 6'h00
`endif

// [core/pps_pkg.sv]
// Types and shared decode for the peripheral input pin select block.
`include "pps_params.svh"
package pps_pkg;
  typedef logic [`PPS_SEL_W-1:0] pps_sel_t;
  typedef enum logic [1:0] {
    pps_bus_idle = 2'b00,
    pps_bus_ack = 2'b01
  } pps_bus_state_t;

  // A selection is usable only if its port code names a port that this variant has.
  function automatic logic pps_sel_ok(input pps_sel_t sel, input logic [`PPS_NUM_PORTS-1:0] present);
    logic [`PPS_PORT_W-1:0] port;
    logic ok;
    port = sel[`PPS_PORT_LSB +: `PPS_PORT_W];
    ok = 1'b0;
    if (port < 3'h6) begin
      ok = present[port];
    end
    return ok;
  endfunction
endpackage

// [core/pps_route.sv]
// Routes one selected port pin to one peripheral input.
`timescale 1ns/1ps
`include "pps_params.svh"
module pps_route
  import pps_pkg::*;
#(
  parameter int NUM_PORTS = `PPS_NUM_PORTS,
  parameter logic [`PPS_NUM_PORTS-1:0] PORT_PRESENT = `PPS_PORT_PRESENT_ALL
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire pps_sel_t i_sel,
  input wire logic [NUM_PORTS*`PPS_PINS_PER_PORT-1:0] i_pins,
  output logic o_level,
  output logic o_reserved
);
  logic [5:0] flat_idx;
  logic next_level;
  logic ok;

  always_comb begin
    ok = pps_sel_ok(i_sel, PORT_PRESENT);
    flat_idx = i_sel[`PPS_PORT_LSB +: `PPS_PORT_W] * 6'd8 + {3'h0, i_sel[`PPS_PIN_LSB +: `PPS_PIN_W]};
    next_level = 1'b0;
    // Reserved or absent ports feed a steady zero rather than a floating index.
    if (ok && (flat_idx < 6'(NUM_PORTS * `PPS_PINS_PER_PORT))) begin
      next_level = i_pins[flat_idx];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_level <= 1'b0;
      o_reserved <= 1'b0;
    end else begin
      o_level <= next_level;
      o_reserved <= ~ok;
    end
  end
endmodule

// [core/pps_top.sv]
// Peripheral input pin select: per-input selection registers on classic Wishbone and the pin routing.
//
// Overview of operation
// - One read/write selection register per peripheral input, six-bit field in low bits.
// - Field bits 5..3 pick the port, A through F; D..F only on some variants.
// - Field bits 2..0 pick the pin number within the selected port.
// - Bits 7 and 6 ignore writes and read as zero.
// - Power-on/brown-out reset loads each input's default; other resets keep the field.
`timescale 1ns/1ps
`include "pps_params.svh"
module pps_top
  import pps_pkg::*;
#(
  parameter int NUM_INPUTS = 8,
  parameter int NUM_PORTS = `PPS_NUM_PORTS,
  parameter logic [`PPS_NUM_PORTS-1:0] PORT_PRESENT = `PPS_PORT_PRESENT_ALL,
  parameter logic [NUM_INPUTS*`PPS_SEL_W-1:0] DEFAULT_SEL = '0
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_other_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [`PPS_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [NUM_PORTS*`PPS_PINS_PER_PORT-1:0] i_pins,
  output logic [NUM_INPUTS-1:0] o_periph_in
);
  pps_sel_t sel_reg [NUM_INPUTS];
  pps_bus_state_t bus_state;
  logic [NUM_PORTS*`PPS_PINS_PER_PORT-1:0] pins_meta;
  logic [NUM_PORTS*`PPS_PINS_PER_PORT-1:0] pins_sync;
  logic [NUM_INPUTS-1:0] reserved;
  logic [31:0] next_rdata;
  logic req;
  logic commit;

  // The write path and the read mux must agree on which address holds which selection.
  function automatic logic sel_hit(input logic [`PPS_ADR_W-1:0] adr, input int k);
    return adr == 8'(`PPS_SEL_BASE + k * `PPS_SEL_STRIDE);
  endfunction

  assign req = i_wb_cyc & i_wb_stb;
  // A write lands on the edge where the master sees ack, so each ack writes once; a held request is acked and writes again two cycles later.
  assign commit = req & i_wb_we & o_wb_ack & i_wb_sel[0];

  // Pins are asynchronous to the core clock, so two stages precede any routing logic.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else begin
      pins_meta <= i_pins;
      pins_sync <= pins_meta;
    end
  end

  // Only the power-on/brown-out reset touches the selections; other resets leave them alone.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int k = 0; k < NUM_INPUTS; k++) begin
        sel_reg[k] <= DEFAULT_SEL[k*`PPS_SEL_W +: `PPS_SEL_W];
      end
    end else if (commit) begin
      for (int k = 0; k < NUM_INPUTS; k++) begin
        if (sel_hit(i_wb_adr, k)) begin
          sel_reg[k] <= i_wb_dat[`PPS_SEL_W-1:0];
        end
      end
    end
  end

  // Bus handshake restarts on any reset, unlike the selections.
  always_ff @(posedge i_clk) begin
    if (i_srst || i_other_rst) begin
      bus_state <= pps_bus_idle;
      o_wb_ack <= 1'b0;
    end else begin
      case (bus_state)
        pps_bus_idle: begin
          o_wb_ack <= req;
          if (req) begin
            bus_state <= pps_bus_ack;
          end
        end
        pps_bus_ack: begin
          o_wb_ack <= 1'b0;
          bus_state <= pps_bus_idle;
        end
        default: begin
          o_wb_ack <= 1'b0;
          bus_state <= pps_bus_idle;
        end
      endcase
    end
  end

  always_comb begin
    next_rdata = 32'h0;
    for (int k = 0; k < NUM_INPUTS; k++) begin
      if (sel_hit(i_wb_adr, k)) begin
        next_rdata = {26'h0, sel_reg[k]};
      end
    end
    if (i_wb_adr == `PPS_LEVEL_OFS) begin
      next_rdata = 32'(o_periph_in);
    end
    if (i_wb_adr == `PPS_RSVD_OFS) begin
      next_rdata = 32'(reserved);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || i_other_rst) begin
      o_wb_dat <= 32'h0;
    end else if (bus_state == pps_bus_idle && req && !i_wb_we) begin
      o_wb_dat <= next_rdata;
    end
  end

  for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_route
    pps_route #(
      .NUM_PORTS(NUM_PORTS),
      .PORT_PRESENT(PORT_PRESENT)
    ) u_route (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_sel(sel_reg[g]),
      .i_pins(pins_sync),
      .o_level(o_periph_in[g]),
      .o_reserved(reserved[g])
    );
  end
endmodule

// [testbench/pps_assertions.sv]
// Bus timing and routing checks for the pin select block.
`timescale 1ns/1ps
module pps_chk (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [47:0] i_pins,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic [7:0] o_periph_in
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  property p_take; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
  a_take: assert property (p_take) else $error("ack late");
  property p_pulse; o_wb_ack |=> !o_wb_ack; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_idle; !(i_wb_cyc && i_wb_stb) |=> !o_wb_ack; endproperty
  a_idle: assert property (p_idle) else $error("ack unasked");
  property p_zero; o_wb_ack && !i_wb_we && i_wb_adr < 8'h40 |-> o_wb_dat[31:6] == '0; endproperty
  a_zero: assert property (p_zero) else $error("upper bits set");
  property p_srst; disable iff (1'b0) i_srst |=> !o_wb_ack && o_periph_in == '0; endproperty
  a_srst: assert property (p_srst) else $error("reset state wrong");
  // Pins and selections quiet long enough that the sync stages have settled.
  property p_route; (!i_wb_cyc && $stable(i_pins))[*5] |=> $stable(o_periph_in); endproperty
  a_route: assert property (p_route) else $error("input moved");
endmodule
bind pps_top pps_chk i_chk (.i_clk, .i_srst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_pins,
  .o_wb_dat, .o_wb_ack, .o_periph_in);

// [testbench/pps_pads.sv]
// Port pin levels as the pads hand them to the block.
`timescale 1ns/1ps
module pps_pads (
  input wire logic i_clk,
  input wire logic [47:0] i_level,
  output logic [47:0] o_pins
);
  always_ff @(posedge i_clk) o_pins <= i_level;
endmodule

// [testbench/tb.sv]
// Bench for the pin select block: bus tasks and routing tests.
`timescale 1ns/1ps
module tb;
  logic i_clk = 1'b0, i_srst = 1'b1, i_other_rst = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
  logic [7:0] i_wb_adr = '0, o_periph_in;
  logic [3:0] i_wb_sel = 4'h1;
  logic [31:0] i_wb_dat = '0, o_wb_dat, rd;
  logic [47:0] lvl = '0, i_pins;
  logic o_wb_ack;
  int err_count = 0, comparisons = 0;
  initial forever #2 i_clk = ~i_clk;
  pps_top i_dut (.i_clk, .i_srst, .i_other_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
    .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_pins, .o_periph_in);
  pps_pads i_pads (.i_clk, .i_level(lvl), .o_pins(i_pins));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("compared %0d, mismatched %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'h3, we, a, d};
    for (n = 0; n < 20 && o_wb_ack !== 1'b1; n++) @(posedge i_clk);
    rd = o_wb_dat;
    {i_wb_cyc, i_wb_stb} <= 2'h0;
    err_count += int'(n == 20);
    if (n == 20) close_out();
    @(posedge i_clk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, '0);
    chk(nm, rd, e);
  endtask
  task automatic settle;
    repeat (5) @(posedge i_clk);
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    rchk("sel0", 8'h00, 32'h0);
    wb(1'b1, 8'h04, 32'hffff_ffff);
    rchk("sel1", 8'h04, 32'h3f);
    rchk("unmapped", 8'h80, 32'h0);
    $display("register test done");
    // Each pass visits a new pin code; the port code wraps over the six ports.
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, 8'h00, 32'(i % 6 * 8 + i));
      lvl <= 48'h1 << (i % 6 * 8 + i);
      settle();
      chk("route hi", o_periph_in[0], 1'b1);
      lvl <= ~(48'h1 << (i % 6 * 8 + i));
      settle();
      chk("route lo", o_periph_in[0], 1'b0);
    end
    $display("routing test done");
    wb(1'b1, 8'h00, 32'h31);
    lvl <= '1;
    settle();
    chk("rsvd port", o_periph_in[0], 1'b0);
    rchk("rsvd flags", 8'h44, 32'h3);
    rchk("levels", 8'h40, 32'hfc);
    i_other_rst <= 1'b1;
    @(posedge i_clk);
    i_other_rst <= 1'b0;
    @(posedge i_clk);
    rchk("kept", 8'h04, 32'h3f);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    rchk("reloaded", 8'h04, 32'h0);
    $display("reset test done");
    close_out();
  end
endmodule
